// *** sasc_pkg.sv ***
/*
 Constants for the SAR converter sequencer control block.
 Assumes a 32-bit APB slave with each register on one aligned word.
*/
// Notes on behaviour
// - Trigger field picks what ends sampling; 0000 software, 0111 internal counter.
// - Manual mode samples on software set; auto mode restarts sampling after conversion.
// - Sample bit is 1 while sampling, 0 while holding; hardware may change it.
// - Done flag sets on conversion end, clears on start; software may clear.
// - Resolution bit set selects 12-bit, clear selects 10-bit.
// - Format field: unsigned/signed right justified, unsigned/signed fractional left.
// - Buffer-mode select only acts while extended DMA enable is set.
// - With extended DMA, increment-rate codes 0000/0001 pick one or two channels; the code steps the offset after one or two conversions.
// - Without extended DMA, increment rate counts conversions per event, 1 to 32.
// - Fill mode clear: one 26-word buffer; set: halves at 0 and 12 alternate.
// - Fill mode and half status apply only when channel-indexed buffering is off.
// - Alternate input set toggles Sample A and B selects; clear always A.
// - Scan enable set steps through scan channels; clear means no scanning.
// - Clock-source bit set picks RC clock, clear a system-derived clock.
// - Extended sampling flag reads 1 while sampling continues after sample bit clears.
// - Auto-sample time field gives sampling duration in conversion clock periods.
// - Conversion clock period is value+1 instruction cycles; 64 and above reserved.
// - Buffer-size field allocates 2^value words per channel.
// - Buffer size used only with extended DMA on and buffer-mode select clear.
// - Indirect offset: channel high, index of log2(size) bits, trailing zero.
// - Channel field is 5 bits up to 32 words, 4 at 64, 3 at 128.
// - Offset is OR-ed with DMA base and increments at the increment rate.
package sasc_pkg;
    localparam logic [11:0] OFF_CON1 = 12'h000;
    localparam logic [11:0] OFF_CON2 = 12'h004;
    localparam logic [11:0] OFF_CON3 = 12'h008;
    localparam logic [11:0] OFF_CON4 = 12'h00C;
    localparam logic [11:0] OFF_STAT = 12'h010;
    localparam logic [15:0] CON1_WMASK = 16'hBFF4;
    localparam logic [15:0] CON2_WMASK = 16'hFC7F;
    localparam logic [15:0] CON3_WMASK = 16'hBFFF;
    localparam logic [15:0] CON4_WMASK = 16'h0007;
    localparam int B_ON = 15;
    localparam int B_DMA_BUFFER_MODE_SELECT = 12;
    localparam int B_EXTENDED_DMA_ENABLE = 11;
    localparam int B_RES = 10;
    localparam int B_AUTO_SAMPLE = 2;
    localparam int B_SAMPLE_BIT = 1;
    localparam int B_DONE = 0;
    localparam int B_CIBE = 11;
    localparam int B_SCAN = 10;
    localparam int B_HALF = 7;
    localparam int B_FILL = 1;
    localparam int B_ALT = 0;
    localparam int B_RC = 15;
    localparam int B_EXT = 14;
    localparam logic [3:0] TRIG_SW = 4'h0;
    localparam logic [3:0] TRIG_INT = 4'h1;
    localparam logic [3:0] TRIG_T3 = 4'h2;
    localparam logic [3:0] TRIG_T5 = 4'h3;
    localparam logic [3:0] TRIG_CTMU = 4'h4;
    localparam logic [3:0] TRIG_T1 = 4'h5;
    localparam logic [3:0] TRIG_AUTO = 4'h7;
    localparam logic [4:0] FIFO_LAST = 5'h19;
    localparam logic [4:0] HALF_B_BASE = 5'h0C;
    localparam logic [4:0] HALF_LEN = 5'h0D;
    localparam logic [7:0] DIV_MAX = 8'h3F;
    localparam logic [3:0] CONV_TAD_10 = 4'hC;
    localparam logic [3:0] CONV_TAD_12 = 4'hE;
    localparam int RC_DIV = 4;
    typedef enum logic [1:0] {
        SASC_IDLE = 2'b00,
        SASC_SAMPLE = 2'b01,
        SASC_CONVERT = 2'b11
    } sasc_state_t;
endpackage

// *** sasc_top.sv ***
/*
 Sequencer control for a SAR converter: registers, sampling and conversion
 sequence, buffer pointer and indirect DMA offset. Assumes trigger pins are
 asynchronous and the analog core is modelled only by timing.
*/
// Design decisions made here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module sasc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [5:0] trig_in,
    input wire logic [11:0] conv_data_in,
    output logic [15:0] result_out,
    output logic result_valid,
    output logic [4:0] buf_index,
    output logic [10:0] dma_offset,
    output logic dma_req,
    output logic sample_b_active,
    output logic scan_step,
    output logic rc_clock_sel
);
    import sasc_pkg::*;
    logic [15:0] con1_reg, con2_reg, con3_reg, con4_reg;
    logic [15:0] con1_next, con2_next, con3_next;
    sasc_state_t state_reg;
    logic [5:0] trig_s1_reg, trig_s2_reg, trig_s3_reg;
    logic [7:0] div_reg;
    logic [1:0] rc_reg;
    logic [4:0] sample_bit_cnt_reg;
    logic [3:0] conv_cnt_reg;
    logic [4:0] rate_cnt_reg;
    logic [4:0] buf_reg;
    logic half_reg;
    logic alt_reg;
    logic [6:0] idx_reg;
    logic [4:0] chan_reg;
    logic [31:0] prdata_reg;
    logic [15:0] result_reg;
    logic valid_reg, dma_reg, scan_reg;
    logic [10:0] offset_reg;

    wire wr_en = psel && penable && pwrite;
    wire hit1 = paddr == OFF_CON1;
    wire hit2 = paddr == OFF_CON2;
    wire hit3 = paddr == OFF_CON3;
    wire hit4 = paddr == OFF_CON4;
    wire hit_st = paddr == OFF_STAT;
    wire module_on = con1_reg[B_ON];
    wire ext_dma = con1_reg[B_EXTENDED_DMA_ENABLE];
    wire dma_bm = con1_reg[B_DMA_BUFFER_MODE_SELECT] && ext_dma;
    wire [3:0] trig_src = con1_reg[7:4];
    wire auto_sample = con1_reg[B_AUTO_SAMPLE];
    wire fill_split = con2_reg[B_FILL] && !con2_reg[B_CIBE];
    wire [4:0] rate_sel = con2_reg[6:2];
    wire [4:0] sample_bit_time = con3_reg[12:8];
    wire [7:0] div_sel = (con3_reg[7:0] > DIV_MAX) ? DIV_MAX : con3_reg[7:0];
    wire [2:0] blen = con4_reg[2:0];
    wire pia_mode = ext_dma && !dma_bm;
    wire rc_tick = rc_reg == 2'(RC_DIV - 1);
    wire sys_tick = div_reg >= div_sel;
    wire tad_tick = con3_reg[B_RC] ? rc_tick : sys_tick;
    wire [5:0] trig_rise = trig_s2_reg & ~trig_s3_reg;
    wire sw_write_sample_bit = wr_en && hit1;
    wire sw_clr_sample_bit = sw_write_sample_bit && !pwdata[B_SAMPLE_BIT] && con1_reg[B_SAMPLE_BIT];
    wire sw_set_sample_bit = sw_write_sample_bit && pwdata[B_SAMPLE_BIT];
    wire sample_bit_elapsed = sample_bit_cnt_reg >= sample_bit_time;
    // Trigger decode
    wire trig_hit = (trig_src == TRIG_SW) ? sw_clr_sample_bit :
                    (trig_src == TRIG_INT) ? trig_rise[0] :
                    (trig_src == TRIG_T3) ? trig_rise[1] :
                    (trig_src == TRIG_T5) ? trig_rise[2] :
                    (trig_src == TRIG_CTMU) ? trig_rise[3] :
                    (trig_src == TRIG_T1) ? trig_rise[4] :
                    (trig_src == TRIG_AUTO) ? (tad_tick && sample_bit_elapsed) :
                    trig_rise[5];
    wire in_sample = state_reg == SASC_SAMPLE;
    wire start_conv = module_on && in_sample && trig_hit;
    wire [3:0] conv_len = con1_reg[B_RES] ? CONV_TAD_12 : CONV_TAD_10;
    wire conv_end = state_reg == SASC_CONVERT && tad_tick && conv_cnt_reg == conv_len - 4'h1;
    wire begin_sample_bit = module_on && state_reg == SASC_IDLE &&
                      (sw_set_sample_bit || auto_sample);
    wire [4:0] rate_lim = ext_dma ? {4'h0, rate_sel[0]} : rate_sel;
    wire rate_hit = rate_cnt_reg == rate_lim;
    // Result formatting
    wire [11:0] raw = con1_reg[B_RES] ? conv_data_in : {2'b00, conv_data_in[11:2]};
    wire [15:0] s_sext = con1_reg[B_RES] ? {{4{!raw[11]}}, raw ^ 12'h800} :
                         {{6{!raw[9]}}, raw[9:0] ^ 10'h200};
    wire [15:0] u_left = con1_reg[B_RES] ? {raw, 4'h0} : {raw[9:0], 6'h00};
    wire [15:0] s_left = u_left ^ 16'h8000;
    wire [15:0] formatted = (con1_reg[9:8] == 2'b00) ? {4'h0, raw} :
                            (con1_reg[9:8] == 2'b01) ? s_sext :
                            (con1_reg[9:8] == 2'b10) ? u_left : s_left;
    // Indirect offset
    wire [6:0] idx_mask = 7'((8'h01 << blen) - 8'h01);
    wire [4:0] chan_mask = (blen == 3'h7) ? 5'h07 : (blen == 3'h6) ? 5'h0F : 5'h1F;
    wire [10:0] chan_part = 11'({6'h00, chan_reg & chan_mask} << (4'(blen) + 4'h1));
    wire [10:0] idx_part = {3'h0, idx_reg & idx_mask, 1'b0};
    wire [10:0] offset_now = chan_part | idx_part;
    // Split mode counts within one half; the half flag picks the base
    wire [4:0] buf_next = fill_split ?
                          ((buf_reg == HALF_LEN - 5'h1) ? 5'h00 : buf_reg + 5'h1) :
                          ((buf_reg == FIFO_LAST) ? 5'h00 : buf_reg + 5'h1);
    wire [4:0] buf_addr = (fill_split && half_reg) ? buf_reg + HALF_B_BASE : buf_reg;

    assign con1_next = {con1_reg[15:2] & ~CON1_WMASK[15:2] | pwdata[15:2] & CON1_WMASK[15:2],
                        con1_reg[1:0]};
    assign con2_next = (con2_reg & ~CON2_WMASK) | (pwdata[15:0] & CON2_WMASK);
    assign con3_next = (con3_reg & ~CON3_WMASK) | (pwdata[15:0] & CON3_WMASK);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_s1_reg <= 6'h00;
            trig_s2_reg <= 6'h00;
            trig_s3_reg <= 6'h00;
        end else begin
            trig_s1_reg <= trig_in;
            trig_s2_reg <= trig_s1_reg;
            trig_s3_reg <= trig_s2_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg <= 8'h00;
            rc_reg <= 2'h0;
        end else begin
            div_reg <= sys_tick ? 8'h00 : div_reg + 8'h01;
            rc_reg <= rc_tick ? 2'h0 : rc_reg + 2'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1_reg <= 16'h0000;
            con2_reg <= 16'h0000;
            con3_reg <= 16'h0000;
            con4_reg <= 16'h0000;
            state_reg <= SASC_IDLE;
            sample_bit_cnt_reg <= 5'h00;
            conv_cnt_reg <= 4'h0;
        end else begin
            if (wr_en && hit1) begin
                con1_reg <= con1_next;
            end
            if (wr_en && hit2) begin
                con2_reg <= con2_next;
            end
            if (wr_en && hit3) begin
                con3_reg <= con3_next;
            end
            if (wr_en && hit4) begin
                con4_reg <= pwdata[15:0] & CON4_WMASK;
            end
            if (!module_on) begin
                state_reg <= SASC_IDLE;
                con1_reg[B_SAMPLE_BIT] <= 1'b0;
                con3_reg[B_EXT] <= 1'b0;
            end else begin
                case (state_reg)
                    SASC_IDLE: begin
                        if (begin_sample_bit) begin
                            state_reg <= SASC_SAMPLE;
                            con1_reg[B_SAMPLE_BIT] <= 1'b1;
                            sample_bit_cnt_reg <= 5'h00;
                        end
                    end
                    SASC_SAMPLE: begin
                        if (tad_tick && !sample_bit_elapsed) begin
                            sample_bit_cnt_reg <= sample_bit_cnt_reg + 5'h01;
                        end
                        if (sw_clr_sample_bit && !start_conv) begin
                            con1_reg[B_SAMPLE_BIT] <= 1'b0;
                            con3_reg[B_EXT] <= 1'b1;
                        end
                        if (start_conv) begin
                            state_reg <= SASC_CONVERT;
                            con1_reg[B_SAMPLE_BIT] <= 1'b0;
                            con1_reg[B_DONE] <= 1'b0;
                            con3_reg[B_EXT] <= 1'b0;
                            conv_cnt_reg <= 4'h0;
                        end
                    end
                    SASC_CONVERT: begin
                        if (tad_tick) begin
                            conv_cnt_reg <= conv_cnt_reg + 4'h1;
                        end
                        if (conv_end) begin
                            con1_reg[B_DONE] <= 1'b1;
                            if (auto_sample) begin
                                state_reg <= SASC_SAMPLE;
                                con1_reg[B_SAMPLE_BIT] <= 1'b1;
                                sample_bit_cnt_reg <= 5'h00;
                            end else begin
                                state_reg <= SASC_IDLE;
                            end
                        end
                    end
                    default: begin
                        state_reg <= SASC_IDLE;
                    end
                endcase
                if (wr_en && hit1 && !pwdata[B_DONE] && !conv_end) begin
                    con1_reg[B_DONE] <= 1'b0;
                end
            end
            if (conv_end && rate_hit && fill_split) begin
                con2_reg[B_HALF] <= half_reg ^ (buf_next == 5'h00);
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_cnt_reg <= 5'h00;
            buf_reg <= 5'h00;
            half_reg <= 1'b0;
            alt_reg <= 1'b0;
            idx_reg <= 7'h00;
            chan_reg <= 5'h00;
            result_reg <= 16'h0000;
            valid_reg <= 1'b0;
            dma_reg <= 1'b0;
            scan_reg <= 1'b0;
            offset_reg <= 11'h000;
        end else begin
            // Registered offset still shows the slot of the transfer being requested
            offset_reg <= offset_now;
            valid_reg <= conv_end;
            dma_reg <= conv_end && rate_hit;
            scan_reg <= conv_end && con2_reg[B_SCAN];
            if (!module_on) begin
                rate_cnt_reg <= 5'h00;
                buf_reg <= 5'h00;
                half_reg <= 1'b0;
                alt_reg <= 1'b0;
            end else if (conv_end) begin
                result_reg <= formatted;
                rate_cnt_reg <= rate_hit ? 5'h00 : rate_cnt_reg + 5'h01;
                alt_reg <= con2_reg[B_ALT] ? !alt_reg : 1'b0;
                if (rate_hit) begin
                    buf_reg <= buf_next;
                    if (fill_split && buf_next == 5'h00) begin
                        half_reg <= !half_reg;
                    end
                    if (pia_mode) begin
                        idx_reg <= (idx_reg + 7'h01) & idx_mask;
                        if ((idx_reg & idx_mask) == idx_mask) begin
                            chan_reg <= (chan_reg + 5'h01) & chan_mask;
                        end
                    end
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            if (hit1) begin
                prdata_reg <= {16'h0000, con1_reg};
            end else if (hit2) begin
                prdata_reg <= {16'h0000, con2_reg};
            end else if (hit3) begin
                prdata_reg <= {16'h0000, con3_reg};
            end else if (hit4) begin
                prdata_reg <= {16'h0000, con4_reg};
            end else if (hit_st) begin
                prdata_reg <= {5'h00, offset_now, 11'h000, buf_addr};
            end else begin
                prdata_reg <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign result_out = result_reg;
    assign result_valid = valid_reg;
    assign buf_index = buf_reg;
    assign dma_offset = offset_reg;
    assign dma_req = dma_reg;
    assign sample_b_active = alt_reg;
    assign scan_step = scan_reg;
    assign rc_clock_sel = con3_reg[B_RC];
endmodule
`default_nettype wire

// *** sasc_monitor.sv ***
/*
 Port checker for the converter sequencer control block.
 Assumes it is bound to sasc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module sasc_monitor
    import sasc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic result_valid,
    input wire logic [4:0] buf_index,
    input wire logic [10:0] dma_offset,
    input wire logic dma_req,
    input wire logic sample_b_active,
    input wire logic scan_step,
    input wire logic rc_clock_sel
);
    logic [15:0] c1_reg, c2_reg;
    logic [2:0] size_reg;
    logic rc_reg;
    wire wr_en = psel && penable && pwrite;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Shadow copies of two control words and of the size and clock-source fields written over the bus
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_reg <= 16'h0000;
            c2_reg <= 16'h0000;
            size_reg <= 3'h0;
            rc_reg <= 1'b0;
        end else begin
            if (wr_en && paddr == OFF_CON1) c1_reg <= pwdata[15:0];
            if (wr_en && paddr == OFF_CON2) c2_reg <= pwdata[15:0];
            if (wr_en && paddr == OFF_CON4) size_reg <= pwdata[2:0];
            if (wr_en && paddr == OFF_CON3) rc_reg <= pwdata[B_RC];
        end
    end
    a_offset_even: assert property (dma_offset[0] == 1'b0)
        else $error("offset low bit set");
    a_offset_span: assert property ($past(c1_reg[B_EXTENDED_DMA_ENABLE]) && !$past(c1_reg[B_DMA_BUFFER_MODE_SELECT])
        && $past(size_reg) <= 3'h5
        |-> (dma_offset >> (4'($past(size_reg)) + 4'h6)) == 11'h000)
        else $error("offset wider than channel field allows");
    a_rc_follows: assert property (rc_clock_sel == rc_reg)
        else $error("clock source select differs from written bit");
    a_valid_pulse: assert property (result_valid |=> !result_valid)
        else $error("result valid longer than one cycle");
    a_off_quiet: assert property (!$past(c1_reg[B_ON]) && !$past(c1_reg[B_ON], 2)
        |-> !result_valid && !dma_req)
        else $error("activity while module off");
    a_scan_quiet: assert property (!c2_reg[B_SCAN] && !$past(c2_reg[B_SCAN]) |-> !scan_step)
        else $error("scan step without scan enable");
    a_alt_rise: assert property ($rose(sample_b_active) |-> $past(c2_reg[B_ALT]))
        else $error("sample B selected with alternate input off");
    a_index_fifo: assert property (!c2_reg[B_CIBE] |-> buf_index <= FIFO_LAST)
        else $error("buffer pointer past last entry");
    c_result: cover property (result_valid);
    c_dma: cover property (dma_req);
    c_alt: cover property ($rose(sample_b_active));
endmodule
bind sasc_top sasc_monitor mon_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .result_valid, .buf_index, .dma_offset, .dma_req, .sample_b_active, .scan_step, .rc_clock_sel);
`default_nettype wire

// *** sasc_dma_model.sv ***
/*
 Model of the system DMA controller taking converter results.
 Assumes the offset from the block is valid whenever a request pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module sasc_dma_model #(
    parameter logic [15:0] DEST_BASE = 16'h1000
)(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dma_req,
    input wire logic [10:0] dma_offset,
    output logic [15:0] last_addr,
    output logic [7:0] req_count
);
    // Base keeps the offset bits clear so OR forms the address
    wire [15:0] addr_next = DEST_BASE | {5'h00, dma_offset};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_addr <= 16'h0000;
            req_count <= 8'h00;
        end else if (dma_req) begin
            last_addr <= addr_next;
            req_count <= req_count + 8'h01;
        end
    end
endmodule
`default_nettype wire

// *** tb_top.sv ***
/*
 Self-checking bench for the converter sequencer control block.
 Assumes the package, design, checker and DMA model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sasc_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, conv_data_in;
    logic [31:0] pwdata, prdata, v;
    logic result_valid, dma_req, sample_b_active, scan_step, rc_clock_sel;
    logic [5:0] trig_in;
    logic [15:0] result_out, last_addr;
    logic [4:0] buf_index;
    logic [10:0] dma_offset;
    logic [7:0] req_count, base_cnt;
    logic [31:0] rd_q[$];
    logic [15:0] res_q[$];
    int fails, total_checks, cyc;
    sasc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .trig_in, .conv_data_in, .result_out, .result_valid, .buf_index,
        .dma_offset, .dma_req, .sample_b_active, .scan_step, .rc_clock_sel);
    sasc_dma_model dma_u (.pclk, .presetn, .dma_req, .dma_offset, .last_addr, .req_count);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        rd_q.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask
    // Expected result: left-justified code, then shifted right or made signed
    function automatic logic [15:0] fmt(input logic [1:0] f, input logic r,
        input logic [11:0] d);
        logic [15:0] x;
        x = r ? {d, 4'h0} : {d[11:2], 6'h00};
        case (f)
            2'b00: fmt = x >> (r ? 4 : 6);
            2'b01: fmt = 16'($signed(x ^ 16'h8000) >>> (r ? 4 : 6));
            2'b10: fmt = x;
            default: fmt = x ^ 16'h8000;
        endcase
    endfunction
    // One conversion: software starts sampling, software or a trigger pin ends it
    task automatic conv(input logic [15:0] c1, input logic b_exp);
        conv_data_in <= 12'($urandom);
        apb(1'b1, OFF_CON1, {16'h0000, c1});
        apb(1'b1, OFF_CON1, {16'h0000, c1 | 16'h0002});
        check({31'h0, sample_b_active}, {31'h0, b_exp});
        if (c1[B_ON]) res_q.push_back(fmt(c1[9:8], c1[B_RES], conv_data_in));
        if (c1[7:4] == TRIG_SW) apb(1'b1, OFF_CON1, {16'h0000, c1});
        else trig_in <= 6'h01 << (c1[7:4] - 4'h1);
        repeat (3) @(posedge pclk);
        trig_in <= 6'h00;
        while (res_q.size() != 0) @(posedge pclk);
        rd(OFF_CON1, {16'h0000, (c1 & CON1_WMASK) | {15'h0, c1[B_ON]}});
    endtask
    // Results and read data are compared against the oldest note
    always @(posedge pclk) begin
        if (psel && penable && !pwrite && pready) check(prdata, rd_q.pop_front());
        if (result_valid) check({16'h0, result_out}, res_q.size() > 0 ?
            {16'h0, res_q.pop_front()} : 32'h0001_0000);
        cyc++;
        if (cyc == 30000) begin
            fails++;
            print_verdict();
        end
    end
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, trig_in, conv_data_in} = '0;
        void'($urandom(78691));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 5; i++) rd(12'(i * 4), 32'h0);
        v = $urandom & 32'hFFFF_FF3F;
        apb(1'b1, OFF_CON4, v);
        rd(OFF_CON4, v & 32'h7);
        apb(1'b1, OFF_CON2, v);
        rd(OFF_CON2, v & {16'h0, CON2_WMASK});
        apb(1'b1, OFF_CON3, v);
        rd(OFF_CON3, v & {16'h0, CON3_WMASK});
        apb(1'b1, 12'h014, v);
        rd(12'h014, 32'h0);
        apb(1'b1, OFF_CON3, 32'h0000_0200);
        apb(1'b1, OFF_CON2, 32'h0);
        for (int f = 0; f < 8; f++) conv(16'h8000 | 16'(f << 8), 1'b0);
        for (int t = 1; t < 6; t++) conv(16'h8400 | 16'(t << 4), 1'b0);
        conv(16'h0000, 1'b0);
        apb(1'b1, OFF_CON2, 32'h0000_0403);
        conv(16'h8400, 1'b0);
        conv(16'h8400, 1'b1);
        check({27'h0, buf_index}, 32'h2);
        rd(OFF_CON2, 32'h0000_0403);
        apb(1'b1, OFF_CON2, 32'h0000_0004);
        base_cnt = req_count;
        conv_data_in <= 12'($urandom);
        @(posedge pclk);
        repeat (4) res_q.push_back(fmt(2'b00, 1'b1, conv_data_in));
        apb(1'b1, OFF_CON1, 32'h0000_8474);
        while (res_q.size() != 0) @(posedge pclk);
        apb(1'b1, OFF_CON1, 32'h0);
        check({24'h0, req_count - base_cnt}, 32'h2);
        apb(1'b1, OFF_CON2, 32'h0);
        apb(1'b1, OFF_CON4, $urandom & 32'h7);
        base_cnt = req_count;
        conv(16'h8C00, 1'b0);
        check({16'h0, last_addr}, 32'h0000_1000);
        conv(16'h8C00, 1'b0);
        check({16'h0, last_addr}, 32'h0000_1002);
        check({24'h0, req_count - base_cnt}, 32'h2);
        apb(1'b1, OFF_CON2, 32'h0000_0800);
        repeat (2) conv(16'h9C00, 1'b0);
        check({16'h0, last_addr}, 32'h0000_1004);
        print_verdict();
    end
endmodule
`default_nettype wire
